// ### logic/scs_pkg.sv
// Package for the system clock source select block
package scs_pkg;

  // Clock source fuse codes
  typedef enum logic [1:0] {
    SCS_SRC_XTAL_HS = 2'b00,
    SCS_SRC_XTAL_LS = 2'b01,
    SCS_SRC_EXT_CLK = 2'b10,
    SCS_SRC_INT_RC  = 2'b11
  } scs_src_t;

  // Register port addresses (8-bit special-function space)
  localparam logic [7:0] SCS_ADDR_CLK_CTRL  = 8'h8f;
  localparam logic [7:0] SCS_ADDR_STATUS    = 8'h90;
  localparam logic [7:0] SCS_ADDR_RC_TRIM   = 8'h91;
  localparam logic [7:0] SCS_ADDR_SIG_ADDR  = 8'h92;
  localparam logic [7:0] SCS_ADDR_SIG_DATA  = 8'h93;
  localparam logic [7:0] SCS_ADDR_STARTUP   = 8'h94;

  localparam logic [7:0] SCS_CLK_CTRL_RESET = 8'h00;
  localparam int         SCS_COE_BIT        = 0;
  localparam int         SCS_CDV_LSB        = 1;
  localparam int         SCS_TPS_LSB        = 4;

  // Signature space locations
  localparam logic [15:0] SCS_SIG_LOC_CAL_IAP  = 16'h0180;
  localparam logic [15:0] SCS_USER_ROW_SPACE_LOC_CAL     = 16'h0080;
  localparam logic [15:0] SCS_SIG_LOC_FACTORY  = 16'h0008;
  localparam int          SCS_USER_CAL_BYTE    = 128;
  localparam int          SCS_FACTORY_CAL_BYTE = 8;

  // Default factory trim; arbitrary neutral value
  localparam logic [7:0] SCS_FACTORY_CAL_DEF = 8'h80;

  // Start-up delays in cycles per source
  localparam logic [15:0] SCS_START_XTAL_HS = 16'h0400;
  localparam logic [15:0] SCS_START_XTAL_LS = 16'h1000;
  localparam logic [15:0] SCS_START_EXT_CLK = 16'h0010;
  localparam logic [15:0] SCS_START_INT_RC  = 16'h0040;

  // Register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } scs_bus_req_t;

  // Port 4 pins 0 and 1 as seen by the port logic
  typedef struct packed {
    logic p0_in_en;
    logic p0_out_en;
    logic p1_in_en;
    logic p1_out_en;
  } scs_port4_ctl_t;

endpackage

// ### logic/scs_clkout.sv
// Glitch-free half-rate clock output gate
`timescale 1ns/1ns
`default_nettype none
module scs_clkout
  import scs_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic nrst,
  input  wire logic allow,
  output logic      clk_out,
  output logic      active
);

  logic half_q;
  logic active_q;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      half_q <= 1'b0;
    end else begin
      half_q <= ~half_q;
    end
  end

  // Gate changes only while the half-rate phase is low
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      active_q <= 1'b0;
    end else if (!half_q) begin
      active_q <= allow; // RULE_16
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      clk_out <= 1'b0;
    end else begin
      clk_out <= active_q & ~half_q; // RULE_12
    end
  end

  assign active = active_q;

endmodule
`default_nettype wire

// ### logic/scs_top.sv
// System clock source select, trim storage and clock-out control
// What this block does
// RULE_01: Clock source comes from two fuse bits, never a runtime register.
// RULE_02: Fuse 00 high-speed crystal, 01 low-speed, 10 external, 11 RC.
// RULE_03: After reset there is no CPU clock division.
// RULE_04: Start-up delay after reset or wake depends on selected source.
// RULE_05: Crystal modes disable input and output of port 4 pins 0, 1.
// RULE_06: External mode disables amplifier and uses input pin as clock.
// RULE_07: External mode lets output pin be free, port pin or clock out.
// RULE_08: RC mode releases both oscillator pins to port 4 use.
// RULE_09: RC trim comes from user signature byte 128.
// RULE_10: Trim writable at signature 0180H and user row 0080H.
// RULE_11: Factory trim copy readable at signature location 0008H.
// RULE_12: Half-rate clock out only in external or RC mode.
// RULE_13: Clock out only while clock-out enable bit is 1.
// RULE_14: Software makes port 4 pin 1 an output before using clock out.
// RULE_15: Clock control register at 8FH, resets zero, enable in bit 0.
// RULE_16: Clock output starts and stops only at a low half-rate phase.
`timescale 1ns/1ns
`default_nettype none
module scs_top
  import scs_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic [1:0]  clk_src_fuse,
  input  wire logic        wake_event,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        prog_wr,
  input  wire logic [15:0] prog_addr,
  input  wire logic [7:0]  prog_wdata,
  input  wire logic        osc_input_pin,
  output logic             amp_enable,
  output logic             ext_clk_direct,
  output logic             ext_clk_level,
  output logic      [7:0]  rc_trim,
  output logic      [2:0]  cpu_clk_div,
  output logic             startup_busy,
  input  wire logic        port4_pin1_is_output,
  input  wire logic        port4_pin1_gpio_out,
  output logic             osc_output_pin_o,
  output logic             osc_output_pin_oe,
  output scs_port4_ctl_t   port4_ctl
);

  scs_bus_req_t   req;
  scs_src_t       src_q;
  logic [7:0]     clk_ctrl_q;
  logic [7:0]     user_cal_q;
  logic [7:0]     factory_cal_q;
  logic [15:0]    sig_addr_q;
  logic [15:0]    start_cnt_q;
  logic           fuse_taken_q;
  logic [7:0]     rdata_d;
  logic           crystal_mode;
  logic           clkout_allow;
  logic           clkout_wave;
  logic           clkout_active;

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  function automatic logic [15:0] startup_of(input scs_src_t s);
    unique case (s)
      SCS_SRC_XTAL_HS: startup_of = SCS_START_XTAL_HS;
      SCS_SRC_XTAL_LS: startup_of = SCS_START_XTAL_LS;
      SCS_SRC_EXT_CLK: startup_of = SCS_START_EXT_CLK;
      SCS_SRC_INT_RC:  startup_of = SCS_START_INT_RC;
    endcase
  endfunction

  // Fuses are caught once after reset release; software cannot change them
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      src_q        <= SCS_SRC_XTAL_HS;
      fuse_taken_q <= 1'b0;
    end else if (!fuse_taken_q) begin
      src_q        <= scs_src_t'(clk_src_fuse); // RULE_01 RULE_02
      fuse_taken_q <= 1'b1;
    end
  end

  // Start-up delay is reloaded on reset release and on each wake
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      start_cnt_q <= 16'hffff;
    end else if (!fuse_taken_q) begin
      start_cnt_q <= startup_of(scs_src_t'(clk_src_fuse)); // RULE_04
    end else if (wake_event) begin
      start_cnt_q <= startup_of(src_q); // RULE_04
    end else if (start_cnt_q != 16'h0000) begin
      start_cnt_q <= start_cnt_q - 16'h0001;
    end
  end

  assign startup_busy = start_cnt_q != 16'h0000;

  // Clock control register
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      clk_ctrl_q <= SCS_CLK_CTRL_RESET; // RULE_03 RULE_15
    end else if (req.wr && req.addr == SCS_ADDR_CLK_CTRL) begin
      clk_ctrl_q <= req.wdata; // RULE_15
    end
  end

  assign cpu_clk_div = clk_ctrl_q[SCS_CDV_LSB +: 3]; // RULE_03

  // Signature pointer for in-application access
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sig_addr_q <= 16'h0000;
    end else if (req.wr && req.addr == SCS_ADDR_SIG_ADDR) begin
      sig_addr_q <= {8'h01, req.wdata};
    end
  end

  // User trim byte: in-app write at 0180H, programmer write at 0080H
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      user_cal_q <= SCS_FACTORY_CAL_DEF;
    end else if (prog_wr && prog_addr == SCS_USER_ROW_SPACE_LOC_CAL) begin
      user_cal_q <= prog_wdata; // RULE_10
    end else if (req.wr && req.addr == SCS_ADDR_SIG_DATA
                 && sig_addr_q == SCS_SIG_LOC_CAL_IAP) begin
      user_cal_q <= req.wdata; // RULE_10
    end else if (req.wr && req.addr == SCS_ADDR_RC_TRIM) begin
      user_cal_q <= req.wdata;
    end
  end

  // Factory copy is read-only for software
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      factory_cal_q <= SCS_FACTORY_CAL_DEF; // RULE_11
    end else begin
      factory_cal_q <= factory_cal_q;
    end
  end

  assign rc_trim = user_cal_q; // RULE_09

  // Source-dependent pin use
  assign crystal_mode = (src_q == SCS_SRC_XTAL_HS) ||
                        (src_q == SCS_SRC_XTAL_LS);
  assign amp_enable     = crystal_mode; // RULE_06
  assign ext_clk_direct = (src_q == SCS_SRC_EXT_CLK); // RULE_06
  assign ext_clk_level  = ext_clk_direct & osc_input_pin; // RULE_06

  always_comb begin
    port4_ctl.p0_in_en  = (src_q == SCS_SRC_INT_RC); // RULE_05 RULE_08
    port4_ctl.p0_out_en = (src_q == SCS_SRC_INT_RC); // RULE_05 RULE_08
    port4_ctl.p1_in_en  = !crystal_mode; // RULE_05 RULE_07 RULE_08
    port4_ctl.p1_out_en = !crystal_mode; // RULE_05 RULE_07 RULE_08
  end

  // Clock out needs a non-crystal source, the enable bit and pin as output
  assign clkout_allow = !crystal_mode && clk_ctrl_q[SCS_COE_BIT]
                        && port4_pin1_is_output; // RULE_12 RULE_13 RULE_14

  scs_clkout u_clkout (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .allow   (clkout_allow),
    .clk_out (clkout_wave),
    .active  (clkout_active)
  );

  // Pin 1 carries either the divided clock or the port data
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      osc_output_pin_o  <= 1'b0;
      osc_output_pin_oe <= 1'b0;
    end else begin
      osc_output_pin_oe <= !crystal_mode && port4_pin1_is_output; // RULE_07
      osc_output_pin_o  <= clkout_active ? clkout_wave
                                         : port4_pin1_gpio_out; // RULE_07
    end
  end

  // Read decode; unmapped addresses return zero
  always_comb begin
    rdata_d = 8'h00;
    unique case (req.addr)
      SCS_ADDR_CLK_CTRL: rdata_d = clk_ctrl_q;
      SCS_ADDR_STATUS:   rdata_d = {3'h0, startup_busy, clkout_active,
                                    crystal_mode, src_q};
      SCS_ADDR_RC_TRIM:  rdata_d = user_cal_q;
      SCS_ADDR_SIG_ADDR: rdata_d = sig_addr_q[7:0];
      SCS_ADDR_SIG_DATA: begin
        if (sig_addr_q == SCS_SIG_LOC_CAL_IAP) begin
          rdata_d = user_cal_q;
        end else if (sig_addr_q[7:0] == SCS_SIG_LOC_FACTORY[7:0]) begin
          rdata_d = factory_cal_q; // RULE_11
        end
      end
      SCS_ADDR_STARTUP:  rdata_d = start_cnt_q[15:8];
      default:           rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= req.rd ? rdata_d : 8'h00;
    end
  end

endmodule
`default_nettype wire

// ### tb/scs_ext_osc.sv
// External clock driver model for the oscillator input
`timescale 1ns/1ns
`default_nettype none
module scs_ext_osc #(parameter int HALF = 17) (
  input  wire logic run,
  output logic      clk_o
);
  // Phase unrelated to the system clock; rests low when not driving
  initial clk_o = 1'b0;
  always #HALF clk_o = run ? ~clk_o : 1'b0;
endmodule
`default_nettype wire

// ### tb/scs_top_props.sv
// Port assertions for the clock source select block
`timescale 1ns/1ns
`default_nettype none
module scs_top_props
  import scs_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       nrst,
  input wire logic [1:0] clk_src_fuse,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       osc_input_pin,
  input wire logic       amp_enable,
  input wire logic       ext_clk_direct,
  input wire logic       ext_clk_level,
  input wire logic [2:0] cpu_clk_div,
  input wire logic       startup_busy,
  input wire logic       osc_output_pin_o,
  input wire scs_port4_ctl_t port4_ctl
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  logic coe_m;
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst) coe_m <= 1'b0;
    else if (reg_wr && reg_addr == SCS_ADDR_CLK_CTRL) coe_m <= reg_wdata[0];
  AST_XTAL_PINS: assert property ($past(nrst) && !clk_src_fuse[1] |->
    amp_enable && port4_ctl == 4'h0) else $error("crystal pins");
  AST_EXT_DIRECT: assert property ($past(nrst) && clk_src_fuse == 2'h2 |->
    !amp_enable && ext_clk_direct && ext_clk_level == osc_input_pin)
    else $error("external path");
  AST_RC_PINS: assert property ($past(nrst) && clk_src_fuse == 2'h3 |->
    !amp_enable && port4_ctl.p0_in_en && port4_ctl.p0_out_en)
    else $error("rc pins");
  AST_OUT_SRC: assert property (osc_output_pin_o |-> clk_src_fuse[1])
    else $error("clock out in crystal mode");
  AST_OUT_GATE: assert property ((!coe_m) [*4] |-> !osc_output_pin_o)
    else $error("clock out while disabled");
  AST_WHOLE: assert property ($rose(osc_output_pin_o) |=> !osc_output_pin_o)
    else $error("clock out pulse width");
  AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  AST_DIV_RST: assert property (!$past(nrst) |-> cpu_clk_div == 3'h0)
    else $error("divider not zero");
  AST_EXT_START: assert property (!$past(nrst) && clk_src_fuse == 2'h2 |->
    startup_busy [*8] ##[8:10] !startup_busy) else $error("start delay");
  cover property ($rose(osc_output_pin_o));
  cover property ($fell(startup_busy));
  cover property (reg_rd && reg_addr == SCS_ADDR_CLK_CTRL);
endmodule
bind scs_top scs_top_props scs_top_props_inst (.ref_clk, .nrst, .clk_src_fuse,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .osc_input_pin,
  .amp_enable, .ext_clk_direct, .ext_clk_level, .cpu_clk_div, .startup_busy,
  .osc_output_pin_o, .port4_ctl);
`default_nettype wire

// ### tb/scs_top_tb.sv
// Self-checking bench for the clock source select block
`timescale 1ns/1ns
`default_nettype none
module scs_top_tb;
  import scs_pkg::*;
  logic        ref_clk = 1'b0, nrst = 1'b0, wake = 1'b0, is_out = 1'b0;
  logic        wr = 1'b0, rd = 1'b0, pwr = 1'b0, amp, busy, pin_o, pin_oe;
  logic [1:0]  fuse = 2'h0;
  logic [7:0]  addr = 8'h00, wdata = 8'h00, pdata = 8'h00, rdata, trim, d;
  logic [15:0] paddr = 16'h0000;
  logic [15:0] dly [4] = '{SCS_START_XTAL_HS, SCS_START_XTAL_LS,
                           SCS_START_EXT_CLK, SCS_START_INT_RC};
  logic [2:0]  div;
  wire         osc;
  scs_port4_ctl_t p4;
  int          err_count = 0, checked = 0, n;
  always #5 ref_clk = ~ref_clk;
  scs_ext_osc scs_ext_osc_inst (.run(fuse == 2'h2), .clk_o(osc));
  scs_top scs_top_inst (.ref_clk(ref_clk), .nrst(nrst), .clk_src_fuse(fuse),
    .wake_event(wake), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr),
    .reg_rd(rd), .reg_rdata(rdata), .prog_wr(pwr), .prog_addr(paddr),
    .prog_wdata(pdata), .osc_input_pin(osc), .amp_enable(amp),
    .ext_clk_direct(), .ext_clk_level(), .rc_trim(trim), .cpu_clk_div(div),
    .startup_busy(busy), .port4_pin1_is_output(is_out),
    .port4_pin1_gpio_out(1'b0), .osc_output_pin_o(pin_o),
    .osc_output_pin_oe(pin_oe), .port4_ctl(p4));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    #1 checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  // Count high samples of the clock output over a span of cycles
  task automatic hi(input int cyc, output int r);
    r = 0;
    repeat (cyc) begin
      @(posedge ref_clk);
      #1 r += int'(pin_o === 1'b1);
    end
  endtask
  task automatic print_verdict;
    if (err_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge ref_clk);
    err_count++;
    print_verdict();
  end
  initial begin
    for (int s = 0; s < 4; s++) begin
      @(posedge ref_clk);
      nrst <= 1'b0;
      fuse <= 2'(s);
      is_out <= 1'b0;
      repeat (5) @(posedge ref_clk);
      nrst <= 1'b1;
      n = 0;
      // The loop also counts the load edge itself
      while (busy !== 1'b0 && n < 5000) begin
        @(posedge ref_clk);
        #1 n++;
      end
      chk(16'(n - 1), dly[s]);
      rd_reg(SCS_ADDR_STATUS, d);
      chk(d & 8'h07, {~s[1], s[1:0]});
      rd_reg(SCS_ADDR_CLK_CTRL, d);
      chk(d, SCS_CLK_CTRL_RESET);
      chk(div, 3'h0);
      chk(amp, !s[1]);
      if (!s[1]) chk(p4, 4'h0);
      if (s == 3) chk(p4[3:2], 2'h3);
      if (s[1]) chk(p4[1:0], 2'h3);
      wr_reg(SCS_ADDR_CLK_CTRL, 8'h01);
      is_out <= 1'b1;
      repeat (4) @(posedge ref_clk);
      hi(16, n);
      chk(16'(n), s[1] ? 16'h8 : 16'h0);
      chk(pin_oe, s[1]);
      wr_reg(SCS_ADDR_CLK_CTRL, 8'h00);
      repeat (4) @(posedge ref_clk);
      hi(8, n);
      chk(16'(n), 16'h0);
    end
    wr_reg(SCS_ADDR_RC_TRIM, 8'h5a);
    rd_reg(SCS_ADDR_RC_TRIM, d);
    chk(d, 8'h5a);
    chk(trim, 8'h5a);
    @(posedge ref_clk);
    pwr <= 1'b1;
    paddr <= SCS_USER_ROW_SPACE_LOC_CAL;
    pdata <= 8'h33;
    @(posedge ref_clk);
    pwr <= 1'b0;
    wr_reg(SCS_ADDR_SIG_ADDR, SCS_SIG_LOC_CAL_IAP[7:0]);
    rd_reg(SCS_ADDR_SIG_DATA, d);
    chk(d, 8'h33);
    wr_reg(SCS_ADDR_SIG_DATA, 8'hc3);
    // Let the write edge settle before sampling the trim output
    #1;
    chk(trim, 8'hc3);
    wr_reg(SCS_ADDR_SIG_ADDR, SCS_SIG_LOC_FACTORY[7:0]);
    rd_reg(SCS_ADDR_SIG_DATA, d);
    chk(d, SCS_FACTORY_CAL_DEF);
    rd_reg(8'ha0, d);
    chk(d, 8'h00);
    wr_reg(SCS_ADDR_CLK_CTRL, 8'h06);
    #1;
    chk(div, 3'h3);
    chk(busy, 1'b0);
    @(posedge ref_clk);
    wake <= 1'b1;
    @(posedge ref_clk);
    wake <= 1'b0;
    #1 chk(busy, 1'b1);
    n = 0;
    while (busy !== 1'b0 && n < 5000) begin
      @(posedge ref_clk);
      #1 n++;
    end
    chk(16'(n), SCS_START_INT_RC);
    print_verdict();
  end
endmodule
`default_nettype wire
